// *** core/isv_map.vh ***
// Purpose: constants for the interrupt source and vector selection block
// Assumes: 20-bit CPU address space, byte addressed
// Notes: vector addresses are the low byte of each 4-byte entry
`ifndef ISV_MAP_VH
`define ISV_MAP_VH
`define ISV_AW 20
`define ISV_VEC_BYTES 3'h4
`define ISV_VEC_UND 20'h0FFDC
`define ISV_VEC_OVF 20'h0FFE0
`define ISV_VEC_BRK 20'h0FFE4
`define ISV_BRK_HI_BYTE 20'h0FFE7
`define ISV_BRK_RELOC_MARK 8'hFF
`define ISV_VEC_MATCH 20'h0FFE8
`define ISV_VEC_STEP 20'h0FFEC
`define ISV_VEC_SPECIAL 20'h0FFF0
`define ISV_VEC_ABRK 20'h0FFF4
`define ISV_VEC_RSVD 20'h0FFF8
`define ISV_VEC_RESET 20'h0FFFC
`define ISV_FIXED_LO 20'h0FFDC
`define ISV_FIXED_HI 20'h0FFFF
`define ISV_RELOC_BYTES 9'h100
`define ISV_NUM_PERIPH 32
`define ISV_PERIPH_LO 6'h03
`define ISV_SWINT_ISP_MAX 6'h1F
`define ISV_NUM_MATCH 2
`define ISV_LVL_W 3
`define ISV_LVL_OFF 3'h0
`endif

// *** core/isv_match_mem.v ***
// Purpose: storage of the two match address registers with registered hit flags
// Assumes: written by the CPU register interface, one channel per write
// Notes: hit flags lag the fetch address by one cycle
`timescale 1ns/1ns
`default_nettype none
`include "isv_map.vh"
module isv_match_mem (
  // clock and reset
  input wire core_clk_i,
  input wire reset_n_i,
  // write port
  input wire wr_en_i,
  input wire wr_sel_i,
  input wire [`ISV_AW-1:0] wr_data_i,
  // compare port
  input wire [`ISV_AW-1:0] fetch_addr_i,
  output reg [1:0] hit_o
);
  reg [`ISV_AW-1:0] mem_ff [0:1];
  integer i;
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mem_ff[0] <= {`ISV_AW{1'b0}};
      mem_ff[1] <= {`ISV_AW{1'b0}};
      hit_o <= 2'h0;
    end else begin
      if (wr_en_i) begin
        mem_ff[wr_sel_i] <= wr_data_i;
      end
      for (i = 0; i < 2; i = i + 1) begin
        hit_o[i] <= (mem_ff[i] == fetch_addr_i);
      end
    end
  end
endmodule // isv_match_mem
`default_nettype wire

// *** core/isv_core.v ***
// Purpose: classify interrupt sources and select vector address for the CPU
// Assumes: CPU sequencer supplies opcode strobes, flags and fetch address
// Notes: one request presented per cycle; output holds until acknowledged
//
// Notes on behaviour
// [R1] maskable taken only when enable flag set
// [R2] peripheral requests are all maskable
// [R3] instruction traps ignore enable and levels
// [R4] undefined opcode vectors to 0FFDCh
// [R5] overflow trap only when overflow flag set
// [R6] breakpoint uses relocatable entry if FFh
// [R7] vector call numbers 0..63, 3..31 shared
// [R8] calls 0..31 push and clear stack select
// [R9] calls 32..63 keep stack select
// [R10] special sources share vector 0FFF0h
// [R11] address match per channel enable, 0FFE8h
// [R12] single step and break tool-only
// [R13] four-byte entries hold routine address
// [R14] fixed table 0FFDCh..0FFFFh, reset last
// [R15] fixed entry high bytes left intact
// [R16] relocatable entry at base plus 4n
// [R17] non-maskable first, then highest level
`timescale 1ns/1ns
`default_nettype none
`include "isv_map.vh"
module isv_core (
  // clock and reset
  input wire core_clk_i,
  input wire reset_n_i,
  // cpu flags and instruction events
  input wire int_enable_flag_i,
  input wire overflow_flag_i,
  input wire stack_select_flag_i,
  input wire undefined_opcode_trap_op_i,
  input wire overflow_trap_op_i,
  input wire breakpoint_op_i,
  input wire brk_hi_byte_ff_i,
  input wire vcall_op_i,
  input wire [5:0] vcall_num_i,
  input wire [`ISV_AW-1:0] fetch_addr_i,
  input wire fetch_valid_i,
  input wire ack_i,
  // special sources
  input wire watchdog_req_i,
  input wire osc_stop_req_i,
  input wire volt_mon1_req_i,
  input wire volt_mon2_req_i,
  // configuration
  input wire [`ISV_AW-1:0] vector_table_base_reg_i,
  input wire [1:0] match_enable_reg_i,
  input wire match_wr_en_i,
  input wire match_wr_sel_i,
  input wire [`ISV_AW-1:0] match_wr_data_i,
  // peripheral requests and levels
  input wire [`ISV_NUM_PERIPH-1:0] periph_req_i,
  input wire [`ISV_NUM_PERIPH*`ISV_LVL_W-1:0] periph_lvl_i,
  input wire [`ISV_LVL_W-1:0] cpu_lvl_i,
  // request to cpu
  output reg req_o,
  output reg [`ISV_AW-1:0] vec_addr_o,
  output reg vec_is_reloc_o,
  output reg save_stack_sel_o,
  output reg clear_stack_sel_o,
  output reg [5:0] int_num_o,
  output reg [`ISV_LVL_W-1:0] new_lvl_o,
  output reg special_pend_o
);
  ////////////////////////////////////////////////////////////////////////////
  function [`ISV_AW-1:0] reloc_addr;
    input [`ISV_AW-1:0] base;
    input [5:0] num;
    begin
      // [R16] base plus 4n
      reloc_addr = base + {{(`ISV_AW-8){1'b0}}, num, 2'b00};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // special sources are pins from other blocks: two-flop sync
  reg [3:0] spc_s1_ff;
  reg [3:0] spc_s2_ff;
  reg [3:0] spc_s3_ff;
  // edge only: a level held high must not raise the shared vector again
  wire [3:0] spc_rise = spc_s2_ff & ~spc_s3_ff;
  reg [3:0] spc_pend_ff;
  reg [3:0] nxt_spc_pend;
  wire [1:0] match_hit;
  reg fetch_q_ff;
  reg [1:0] match_pend_ff;

  isv_match_mem isv_match_mem_inst (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .wr_en_i(match_wr_en_i),
    .wr_sel_i(match_wr_sel_i),
    .wr_data_i(match_wr_data_i),
    .fetch_addr_i(fetch_addr_i),
    .hit_o(match_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // maskable arbitration
  reg periph_any;
  reg [5:0] periph_num;
  reg [`ISV_LVL_W-1:0] periph_best;
  reg [`ISV_LVL_W-1:0] lvl_k;
  integer k;
  always @* begin
    periph_any = 1'b0;
    periph_num = 6'h00;
    periph_best = `ISV_LVL_OFF;
    lvl_k = `ISV_LVL_OFF;
    for (k = 0; k < `ISV_NUM_PERIPH; k = k + 1) begin
      lvl_k = periph_lvl_i[k*`ISV_LVL_W +: `ISV_LVL_W];
      // [R2] peripheral maskable with level
      // [R17] highest level wins, lower number on tie
      if (periph_req_i[k] && (k >= 3) && (lvl_k != `ISV_LVL_OFF) &&
          (lvl_k > cpu_lvl_i) && (!periph_any || lvl_k > periph_best)) begin
        periph_any = 1'b1;
        periph_num = k[5:0];
        periph_best = lvl_k;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // selection
  reg nxt_req;
  reg [`ISV_AW-1:0] nxt_vec;
  reg nxt_reloc;
  reg nxt_save;
  reg nxt_clr;
  reg [5:0] nxt_num;
  reg [`ISV_LVL_W-1:0] nxt_lvl;
  reg [1:0] nxt_match_pend;
  wire busy = req_o && !ack_i;
  always @* begin
    nxt_req = 1'b0;
    nxt_vec = vec_addr_o;
    nxt_reloc = 1'b0;
    nxt_save = 1'b0;
    nxt_clr = 1'b0;
    nxt_num = 6'h00;
    nxt_lvl = cpu_lvl_i;
    // hardware set wins over the clear when the special request is selected
    nxt_spc_pend = spc_pend_ff | spc_rise;
    // [R11] match only with channel enabled
    nxt_match_pend = match_pend_ff |
      (fetch_q_ff ? (match_hit & match_enable_reg_i) : 2'h0);
    if (busy) begin
      nxt_req = 1'b1;
      nxt_vec = vec_addr_o;
      nxt_reloc = vec_is_reloc_o;
      nxt_save = save_stack_sel_o;
      nxt_clr = clear_stack_sel_o;
      nxt_num = int_num_o;
      nxt_lvl = new_lvl_o;
    // [R3] traps ignore enable flag
    end else if (undefined_opcode_trap_op_i) begin
      // [R4] undefined opcode vector
      nxt_req = 1'b1;
      nxt_vec = `ISV_VEC_UND;
    end else if (overflow_trap_op_i && overflow_flag_i) begin
      // [R5] overflow trap vector
      nxt_req = 1'b1;
      nxt_vec = `ISV_VEC_OVF;
    end else if (breakpoint_op_i) begin
      // [R6] relocatable fallback on FFh
      nxt_req = 1'b1;
      nxt_reloc = brk_hi_byte_ff_i;
      nxt_vec = brk_hi_byte_ff_i ? reloc_addr(vector_table_base_reg_i, 6'h00)
                                 : `ISV_VEC_BRK;
    end else if (vcall_op_i) begin
      // [R7] call number indexes relocatable table
      nxt_req = 1'b1;
      nxt_reloc = 1'b1;
      nxt_num = vcall_num_i;
      nxt_vec = reloc_addr(vector_table_base_reg_i, vcall_num_i);
      // [R8] low calls use supervisor stack
      // [R9] high calls keep stack select
      nxt_save = (vcall_num_i <= `ISV_SWINT_ISP_MAX);
      nxt_clr = (vcall_num_i <= `ISV_SWINT_ISP_MAX);
    end else if (|nxt_match_pend) begin
      // [R17] non-maskable before maskable
      nxt_req = 1'b1;
      nxt_vec = `ISV_VEC_MATCH;
      nxt_match_pend = nxt_match_pend[0] ? {nxt_match_pend[1], 1'b0} : 2'h0;
    end else if (|nxt_spc_pend) begin
      // [R10] shared special vector
      nxt_req = 1'b1;
      nxt_vec = `ISV_VEC_SPECIAL;
      // a fresh edge behind an older pending one stays set
      nxt_spc_pend = (|spc_pend_ff) ? spc_rise : 4'h0;
    // [R1] maskable gated by enable flag
    end else if (int_enable_flag_i && periph_any) begin
      nxt_req = 1'b1;
      nxt_reloc = 1'b1;
      nxt_num = periph_num;
      nxt_lvl = periph_best;
      nxt_save = 1'b1;
      nxt_clr = 1'b1;
      nxt_vec = reloc_addr(vector_table_base_reg_i, periph_num);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      spc_s1_ff <= 4'h0;
      spc_s2_ff <= 4'h0;
      spc_s3_ff <= 4'h0;
      spc_pend_ff <= 4'h0;
      match_pend_ff <= 2'h0;
      fetch_q_ff <= 1'b0;
      req_o <= 1'b0;
      // [R14] reset entry at table top
      vec_addr_o <= `ISV_VEC_RESET;
      vec_is_reloc_o <= 1'b0;
      save_stack_sel_o <= 1'b0;
      clear_stack_sel_o <= 1'b0;
      int_num_o <= 6'h00;
      new_lvl_o <= `ISV_LVL_OFF;
      special_pend_o <= 1'b0;
    end else begin
      spc_s1_ff <= {volt_mon2_req_i, volt_mon1_req_i, osc_stop_req_i, watchdog_req_i};
      spc_s2_ff <= spc_s1_ff;
      spc_s3_ff <= spc_s2_ff;
      spc_pend_ff <= nxt_spc_pend;
      match_pend_ff <= nxt_match_pend;
      fetch_q_ff <= fetch_valid_i;
      // [R13] cpu branches to entry contents
      req_o <= nxt_req;
      // [R15] entries only addressed, never written
      vec_addr_o <= nxt_vec;
      vec_is_reloc_o <= nxt_reloc;
      save_stack_sel_o <= nxt_save;
      clear_stack_sel_o <= nxt_clr;
      int_num_o <= nxt_num;
      new_lvl_o <= nxt_lvl;
      special_pend_o <= |(spc_pend_ff | spc_rise);
    end
  end
endmodule // isv_core
`default_nettype wire

// *** dv/isv_cpu_model.sv ***
// Purpose: cpu sequencer stand-in that accepts vector requests
// Assumes: one ack pulse per request
// Notes: ack delay comes from the bench, 0 is prompt
`timescale 1ns/1ns
`default_nettype none
module isv_cpu_model (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // request side
  input wire logic req_o,
  input wire logic [3:0] ack_dly_i,
  output logic ack_i
);
  logic [3:0] wait_ff;
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_ff <= 4'h0;
      ack_i <= 1'b0;
    end else begin
      ack_i <= req_o && !ack_i && wait_ff >= ack_dly_i;
      wait_ff <= (req_o && !ack_i) ? wait_ff + 4'h1 : 4'h0;
    end
  end
endmodule // isv_cpu_model
`default_nettype wire

// *** dv/isv_core_properties.sv ***
// Purpose: port checks of vector selection
// Assumes: opcode strobes may overlap; checks mask lower strobes by trap priority
// Notes: bound to every isv_core
`timescale 1ns/1ns
`default_nettype none
`include "isv_map.vh"
module isv_core_properties (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // watched inputs
  input wire logic overflow_flag_i,
  input wire logic undefined_opcode_trap_op_i,
  input wire logic overflow_trap_op_i,
  input wire logic breakpoint_op_i,
  input wire logic brk_hi_byte_ff_i,
  input wire logic vcall_op_i,
  input wire logic [5:0] vcall_num_i,
  input wire logic ack_i,
  input wire logic [`ISV_AW-1:0] vector_table_base_reg_i,
  // watched outputs
  input wire logic req_o,
  input wire logic [`ISV_AW-1:0] vec_addr_o,
  input wire logic vec_is_reloc_o,
  input wire logic save_stack_sel_o,
  input wire logic clear_stack_sel_o,
  input wire logic [5:0] int_num_o
);
  logic go, breakpoint_op, vc;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  assign go = !req_o || ack_i;
  assign breakpoint_op = breakpoint_op_i && !undefined_opcode_trap_op_i && !overflow_trap_op_i && go;
  assign vc = vcall_op_i && !breakpoint_op_i && !undefined_opcode_trap_op_i
    && !overflow_trap_op_i && go;
  a_und_vector: assert property (
    undefined_opcode_trap_op_i && go |=> req_o && vec_addr_o == `ISV_VEC_UND)
    else $error("undefined opcode vector wrong");
  a_ovf_vector: assert property (
    overflow_trap_op_i && overflow_flag_i && !undefined_opcode_trap_op_i && go
    |=> req_o && vec_addr_o == `ISV_VEC_OVF) else $error("overflow vector wrong");
  a_brk_select: assert property (
    breakpoint_op |=> vec_is_reloc_o == $past(brk_hi_byte_ff_i) && vec_addr_o ==
    ($past(brk_hi_byte_ff_i) ? $past(vector_table_base_reg_i) : `ISV_VEC_BRK))
    else $error("breakpoint vector wrong");
  a_call_low: assert property (
    vc && vcall_num_i < 6'h20 |=> save_stack_sel_o && clear_stack_sel_o && vec_addr_o ==
    $past(vector_table_base_reg_i) + {$past(vcall_num_i), 2'b00}) else $error("low call wrong");
  a_call_high: assert property (
    vc && vcall_num_i >= 6'h20 |=> !save_stack_sel_o && !clear_stack_sel_o
    && int_num_o == $past(vcall_num_i)) else $error("high call wrong");
  a_hold_ack: assert property (
    req_o && !ack_i |=> req_o && $stable(vec_addr_o) && $stable(int_num_o))
    else $error("request dropped before ack");
  a_reset_vector: assert property (
    $rose(reset_n_i) |-> !req_o && vec_addr_o == `ISV_VEC_RESET) else $error("reset vector");
  a_fixed_only: assert property (
    req_o && !vec_is_reloc_o |-> vec_addr_o[1:0] == 2'h0 && vec_addr_o >= `ISV_FIXED_LO
    && vec_addr_o < `ISV_VEC_RSVD && vec_addr_o != `ISV_VEC_STEP
    && vec_addr_o != `ISV_VEC_ABRK) else $error("bad fixed vector");
endmodule // isv_core_properties
bind isv_core isv_core_properties isv_core_properties_inst (.*);
`default_nettype wire

// *** dv/isv_core_bench.sv ***
// Purpose: directed bench for vector selection
// Assumes: cpu model acks each request
// Notes: enable flag low except in the maskable test
`timescale 1ns/1ns
`default_nettype none
`include "isv_map.vh"
module isv_core_bench;
  logic core_clk_i, reset_n_i, int_enable_flag_i, overflow_flag_i, stack_select_flag_i;
  logic undefined_opcode_trap_op_i, overflow_trap_op_i, breakpoint_op_i, brk_hi_byte_ff_i;
  logic vcall_op_i, fetch_valid_i, ack_i, watchdog_req_i, osc_stop_req_i, volt_mon1_req_i;
  logic volt_mon2_req_i, match_wr_en_i, match_wr_sel_i, req_o, vec_is_reloc_o;
  logic save_stack_sel_o, clear_stack_sel_o, special_pend_o;
  logic [5:0] vcall_num_i, int_num_o;
  logic [1:0] match_enable_reg_i;
  logic [3:0] ack_dly_i;
  logic [2:0] cpu_lvl_i, new_lvl_o;
  logic [`ISV_AW-1:0] fetch_addr_i, vector_table_base_reg_i, match_wr_data_i, vec_addr_o;
  logic [31:0] periph_req_i;
  logic [95:0] periph_lvl_i;
  logic [5:0] nums [5] = '{6'h00, 6'h03, 6'h1F, 6'h20, 6'h3F};
  int fail_count = 0, tests_run = 0;
  localparam logic [19:0] BASE = 20'h0C000;
  isv_core isv_core_inst (.*);
  isv_cpu_model isv_cpu_model_inst (.*);
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task tick;
    @(posedge core_clk_i);
    #1;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task conclude;
    if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task pulse(input logic [3:0] ops, input logic [5:0] num);
    {vcall_op_i, breakpoint_op_i, overflow_trap_op_i, undefined_opcode_trap_op_i} = ops;
    vcall_num_i = num;
    tick;
    {vcall_op_i, breakpoint_op_i, overflow_trap_op_i, undefined_opcode_trap_op_i} = 4'h0;
  endtask
  // zero vector: nothing may be requested; sv is {care, save}
  task expect_req(input logic [19:0] v, input logic rel, input logic [1:0] sv);
    int n;
    for (n = 0; n < 8 && !req_o; n++) tick;
    chk(req_o, v != 20'h0);
    if (!req_o && v != 20'h0) conclude;
    if (req_o) begin
      chk({vec_addr_o, vec_is_reloc_o}, {v, rel});
      if (sv[1]) chk(save_stack_sel_o, sv[0]);
      periph_req_i = 32'h0;
      for (n = 0; n < 12 && req_o; n++) tick;
      // a request that never drops is a hang and counts as a mismatch
      chk(req_o, 1'b0);
      if (req_o) conclude;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {undefined_opcode_trap_op_i, overflow_trap_op_i, breakpoint_op_i, vcall_op_i} = 4'h0;
    {brk_hi_byte_ff_i, fetch_valid_i, match_wr_en_i, match_wr_sel_i} = 4'h0;
    {watchdog_req_i, osc_stop_req_i, volt_mon1_req_i, volt_mon2_req_i} = 4'h0;
    {reset_n_i, int_enable_flag_i, overflow_flag_i, stack_select_flag_i} = 4'h3;
    {vcall_num_i, match_enable_reg_i, ack_dly_i, cpu_lvl_i} = 15'h0000;
    {fetch_addr_i, match_wr_data_i, periph_req_i, periph_lvl_i} = 168'h0;
    vector_table_base_reg_i = BASE;
    repeat (3) tick;
    chk({req_o, vec_addr_o}, {1'b0, `ISV_VEC_RESET});
    reset_n_i = 1'b1;
    tick;
    pulse(4'h3, 6'h00);
    expect_req(`ISV_VEC_UND, 1'b0, 2'h0);
    pulse(4'h2, 6'h00);
    expect_req(`ISV_VEC_OVF, 1'b0, 2'h0);
    overflow_flag_i = 1'b0;
    pulse(4'h2, 6'h00);
    expect_req(20'h0, 1'b0, 2'h0);
    pulse(4'h4, 6'h00);
    expect_req(`ISV_VEC_BRK, 1'b0, 2'h0);
    brk_hi_byte_ff_i = 1'b1;
    pulse(4'h4, 6'h00);
    expect_req(BASE, 1'b1, 2'h0);
    for (int i = 0; i < 5; i++) begin
      ack_dly_i = i[3:0];
      pulse(4'h8, nums[i]);
      expect_req(BASE + {nums[i], 2'b00}, 1'b1, {1'b1, nums[i] < 6'h20});
    end
    periph_lvl_i[15 +: 3] = 3'h3;
    periph_lvl_i[27 +: 3] = 3'h6;
    periph_req_i = 32'h220;
    expect_req(20'h0, 1'b0, 2'h0);
    {int_enable_flag_i, cpu_lvl_i} = 4'hE;
    expect_req(20'h0, 1'b0, 2'h0);
    cpu_lvl_i = 3'h0;
    tick;
    chk({req_o, int_num_o, new_lvl_o, clear_stack_sel_o}, {1'b1, 6'h09, 3'h6, 1'b1});
    expect_req(BASE + 20'h24, 1'b1, 2'h3);
    int_enable_flag_i = 1'b0;
    for (int i = 0; i < 4; i++) begin
      {watchdog_req_i, osc_stop_req_i, volt_mon1_req_i, volt_mon2_req_i} = 4'h8 >> i;
      tick;
      {watchdog_req_i, osc_stop_req_i, volt_mon1_req_i, volt_mon2_req_i} = 4'h0;
      // two sync flops, then the request edge
      repeat (2) tick;
      chk({req_o, special_pend_o}, 2'h3);
      expect_req(`ISV_VEC_SPECIAL, 1'b0, 2'h0);
    end
    for (int i = 0; i < 4; i++) begin
      {match_wr_en_i, match_wr_sel_i, match_wr_data_i} = {1'b1, i[0], 20'h01230 + i[19:0]};
      match_enable_reg_i = (i < 2) ? 2'h1 << i : 2'h0;
      tick;
      {match_wr_en_i, fetch_valid_i, fetch_addr_i} = {2'b01, 20'h01230 + i[19:0]};
      tick;
      fetch_valid_i = 1'b0;
      expect_req((i < 2) ? `ISV_VEC_MATCH : 20'h0, 1'b0, 2'h0);
    end
    conclude;
  end
endmodule // isv_core_bench
`default_nettype wire
